// *** design/lun_reset_task_mgmt.sv ***
// Top: LU reset sequencing, response arbitration, untagged check, reset effects.
// Assumes task core, link and reset sources share clk; rst_n may be asynchronous.
`timescale 1ns/1ps
module lun_reset_task_mgmt
   import lun_reset_pkg::*;
#(
   parameter int NUM_LUN = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Incoming message bytes
   input wire logic rxValid,
   input wire logic [7:0] rxByte,
   input wire logic rxLast,
   output logic rxReady,
   // Units present
   input wire logic [NUM_LUN-1:0] lunAttached,
   // Task core handshakes
   input wire logic dataReqPending,
   output logic flushReq,
   input wire logic statusPending,
   output logic statusDrainReq,
   // Reset actions on one unit
   output logic [7:0] actLun,
   output logic abortTasks,
   output logic clearAca,
   output logic releaseResv,
   output logic reloadModes,
   output logic unitAttnPowerOn,
   // Other acknowledgements
   input wire logic extValid,
   input wire logic [15:0] extTag,
   input wire logic [31:0] extPath,
   input wire logic [7:0] extCode,
   output logic extReady,
   // Command queue-type check
   input wire logic cmdValid,
   input wire logic [2:0] cmdQueueType,
   input wire logic [15:0] cmdTag,
   input wire logic [31:0] cmdPath,
   output logic cmdReady,
   output logic cmdReject,
   // Node resets
   input wire logic hardResetEvt,
   input wire logic linkResetEvt,
   output logic hardClear,
   // Response bytes out
   output logic txValid,
   output logic [7:0] txByte,
   output logic txLast,
   output logic [31:0] txPath,
   input wire logic txReady,
   // Status
   output logic busy,
   output logic [7:0] lastCode
);
   typedef enum logic [2:0] {S_IDLE, S_FLUSH, S_STATUS, S_ACT, S_SEND, S_WAIT, S_UA} st_t;
   typedef struct packed {
      st_t st;
      logic [15:0] tag;
      logic [31:0] path;
      logic [7:0] lun;
      logic [7:0] code;
      logic isLu;
      logic hardClr;
      logic reject;
      logic [7:0] last;
   } ctl_t;
   ctl_t r, next_r;

   // Reset release synchroniser
   logic [1:0] rstSync;
   logic rstN;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) rstSync <= 2'b00;
      else rstSync <= {rstSync[0], 1'b1};
   end
   assign rstN = rstSync[1];

   // Parsed request
   logic reqValid;
   logic [15:0] reqTag;
   logic [31:0] reqPath;
   logic [7:0] reqLun;
   logic reqTake;
   logic txBusy;
   logic respLoad;

   // Unit is supported and attached
   function automatic logic lunOk(input logic [7:0] lun, input logic [NUM_LUN-1:0] att);
      return (32'(lun) < NUM_LUN) && att[lun[$clog2(NUM_LUN)-1:0]];
   endfunction

   lun_req_parser u_parser (
      .clk(clk),
      .rst_n(rstN),
      .rxValid(rxValid),
      .rxByte(rxByte),
      .rxLast(rxLast),
      .rxReady(rxReady),
      .reqValid(reqValid),
      .reqTag(reqTag),
      .reqPath(reqPath),
      .reqLun(reqLun),
      .reqTake(reqTake)
   );

   lun_resp_tx u_tx (
      .clk(clk),
      .rst_n(rstN),
      .load(respLoad),
      .drop(hardResetEvt),
      .tag(r.tag),
      .path(r.path),
      .code(r.code),
      .busy(txBusy),
      .txValid(txValid),
      .txByte(txByte),
      .txLast(txLast),
      .txPath(txPath),
      .txReady(txReady)
   );

   // Untagged commands are refused
   logic cmdUntagged;
   assign cmdUntagged = cmdQueueType == QTYPE_UNTAGGED; // [RULE22]

   // Arbitration in idle: LU reset, then command reject, then others
   logic idle;
   assign idle = (r.st == S_IDLE) && !hardResetEvt;
   assign reqTake = idle && reqValid;
   assign cmdReady = idle && !reqValid;
   assign extReady = idle && !reqValid && !cmdValid;

   // Sequencer
   always_comb begin
      next_r = r;
      next_r.hardClr = 1'b0;
      next_r.reject = 1'b0;
      case (r.st)
         S_IDLE: begin
            if (reqTake) begin
               next_r.tag = reqTag; // [RULE18]
               next_r.path = reqPath; // [RULE13]
               next_r.lun = reqLun;
               next_r.isLu = 1'b1;
               if (lunOk(reqLun, lunAttached)) begin
                  next_r.code = RC_OK; // [RULE15]
                  next_r.st = S_FLUSH;
               end else begin
                  // Unknown unit: answer only, nothing reset
                  next_r.code = RC_INVALID; // [RULE14]
                  next_r.st = S_SEND;
               end
            end else if (cmdValid && cmdReady) begin
               if (cmdUntagged) begin
                  next_r.tag = cmdTag;
                  next_r.path = cmdPath;
                  next_r.code = RC_INVALID; // [RULE22] [RULE16]
                  next_r.isLu = 1'b0;
                  next_r.reject = 1'b1;
                  next_r.st = S_SEND;
               end
            end else if (extValid && extReady) begin
               next_r.tag = extTag;
               next_r.path = extPath;
               next_r.code = codeSafe(extCode); // [RULE16] [RULE19] [RULE23]
               next_r.isLu = 1'b0;
               next_r.st = S_SEND;
            end
         end
         // Wait for requested write data to arrive and be discarded
         S_FLUSH: begin
            if (!dataReqPending) next_r.st = S_STATUS; // [RULE7]
         end
         // Completed tasks report status before the response
         S_STATUS: begin
            if (!statusPending) next_r.st = S_ACT; // [RULE8]
         end
         // One cycle of reset actions on the unit
         S_ACT: begin
            next_r.st = S_SEND;
         end
         // Load response into the sender
         S_SEND: begin
            if (!txBusy) next_r.st = S_WAIT;
         end
         // Wait for the last response byte to go out
         S_WAIT: begin
            if (!txBusy) begin
               next_r.last = r.code;
               next_r.st = (r.isLu && r.code == RC_OK) ? S_UA : S_IDLE;
            end
         end
         // Raise unit attention, then back to idle
         S_UA: begin
            next_r.st = S_IDLE;
         end
         default: begin
            next_r.st = S_IDLE;
         end
      endcase
      // Node hard resets return the sequencer to idle and pulse hardClear; link resets do nothing here [RULE20]
      if (hardResetEvt) begin
         next_r.st = S_IDLE; // [RULE21]
         next_r.hardClr = 1'b1; // [RULE21]
         next_r.isLu = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) r <= '0;
      else r <= next_r;
   end

   // Action outputs decoded from state flops; only the addressed unit
   assign actLun = r.lun; // [RULE1]
   assign abortTasks = r.st == S_ACT; // [RULE1] [RULE8]
   assign clearAca = r.st == S_ACT; // [RULE2]
   assign releaseResv = r.st == S_ACT; // [RULE2]
   assign reloadModes = r.st == S_ACT; // [RULE3]
   assign unitAttnPowerOn = r.st == S_UA; // [RULE9]
   assign flushReq = r.st == S_FLUSH; // [RULE7]
   assign statusDrainReq = r.st == S_STATUS; // [RULE8]
   assign respLoad = (r.st == S_SEND) && !txBusy; // [RULE10]
   assign cmdReject = r.reject;
   assign hardClear = r.hardClr;
   assign busy = r.st != S_IDLE;
   assign lastCode = r.last;
   // No port reaches transport tables, alerts or other protocols [RULE4]

   property p_act_good_lun;
      @(posedge clk) disable iff (!rstN) abortTasks |-> lunOk(actLun, lunAttached);
   endproperty
   a_act_good_lun: assert property (p_act_good_lun) else $error("reset on bad unit"); // [RULE1]
   property p_bad_lun_no_act;
      @(posedge clk) disable iff (!rstN) (reqTake && !lunOk(reqLun, lunAttached)) |=> !abortTasks [*4];
   endproperty
   a_bad_lun_no_act: assert property (p_bad_lun_no_act) else $error("bad unit was reset"); // [RULE14]
   property p_flushed_first;
      @(posedge clk) disable iff (!rstN) $rose(statusDrainReq) |-> $past(flushReq) && !$past(dataReqPending);
   endproperty
   a_flushed_first: assert property (p_flushed_first) else $error("abort before data flush"); // [RULE7]
   property p_status_first;
      @(posedge clk) disable iff (!rstN) abortTasks |-> $past(statusDrainReq) && !$past(statusPending);
   endproperty
   a_status_first: assert property (p_status_first) else $error("abort before status drained"); // [RULE8]
   property p_act_together;
      @(posedge clk) disable iff (!rstN) abortTasks |-> clearAca && releaseResv && reloadModes;
   endproperty
   a_act_together: assert property (p_act_together) else $error("reset actions split"); // [RULE2]
   property p_resp_follows;
      @(posedge clk) disable iff (!rstN || hardResetEvt) abortTasks |=> r.st == S_SEND;
   endproperty
   a_resp_follows: assert property (p_resp_follows) else $error("no response after reset"); // [RULE10]
   property p_lu_codes;
      @(posedge clk) disable iff (!rstN) (respLoad && r.isLu) |-> (r.code == RC_OK || r.code == RC_INVALID);
   endproperty
   a_lu_codes: assert property (p_lu_codes) else $error("illegal LU reset code"); // [RULE15]
   property p_ua_after;
      @(posedge clk) disable iff (!rstN) unitAttnPowerOn |-> $past(r.st) == S_WAIT && !$past(txBusy);
   endproperty
   a_ua_after: assert property (p_ua_after) else $error("unit attention out of order"); // [RULE9]
   property p_link_quiet;
      @(posedge clk) disable iff (!rstN) (linkResetEvt && !hardResetEvt) |=> !hardClear;
   endproperty
   a_link_quiet: assert property (p_link_quiet) else $error("link reset cleared state"); // [RULE20]
   property p_hard_clear;
      @(posedge clk) disable iff (!rstN) hardResetEvt |=> hardClear && r.st == S_IDLE;
   endproperty
   a_hard_clear: assert property (p_hard_clear) else $error("hard reset not applied"); // [RULE21]
   property p_untagged;
      @(posedge clk) disable iff (!rstN) (cmdValid && cmdReady && cmdUntagged) |=> cmdReject && r.code == RC_INVALID;
   endproperty
   a_untagged: assert property (p_untagged) else $error("untagged command accepted"); // [RULE22]
   property p_tag_kept;
      @(posedge clk) disable iff (!rstN) reqTake |=> r.tag == $past(reqTag);
   endproperty
   a_tag_kept: assert property (p_tag_kept) else $error("tag not copied"); // [RULE18]

   c_lu_ok: cover property (@(posedge clk) disable iff (!rstN) unitAttnPowerOn);
   c_lu_bad: cover property (@(posedge clk) disable iff (!rstN) reqTake && !lunOk(reqLun, lunAttached));
   c_reject: cover property (@(posedge clk) disable iff (!rstN) cmdReject);
   c_ext: cover property (@(posedge clk) disable iff (!rstN) extValid && extReady);
endmodule

// *** design/lun_reset_pkg.sv ***
// Package: message codes, byte layout, return codes, helpers for LU reset logic.
// Assumes one clock domain; all users import the whole package.
// Operation
// RULE1: LU reset aborts only addressed unit's tasks
// RULE2: Also clear ACA, release reservations there
// RULE3: Reload saved mode settings, else defaults
// RULE4: Transport tables, alerts, other protocols untouched
// RULE5: Initiator resets on every logical path used
// RULE6: Initiator should stop outbound data first
// RULE7: Flush requested data before aborting tasks
// RULE8: Status before response, none for aborted
// RULE9: Unit attention for all initiators afterward
// RULE10: Exactly one response per LU reset
// RULE11: Initiator drops aborted commands on response
// RULE12: Request: 83h, 35h, tag, path, unit
// RULE13: Response goes over request's return path
// RULE14: Bad unit: answer FFh, no reset
// RULE15: LU reset code only 00h or FFh
// RULE16: One response format for all acknowledgements
// RULE17: Response: 83h, 03h, tag, return code
// RULE18: Response tag copied from request
// RULE19: Return code values 00h,01h,04h,20h,FFh
// RULE20: Link reset leaves task state alone
// RULE21: Hard resets clear all task state
// RULE22: Untagged queue type never accepted
// RULE23: Never send a reserved return code
package lun_reset_pkg;
   // Message header bytes
   localparam logic [7:0] MSG_CODE = 8'h83;
   localparam logic [7:0] PROTO_LU_RESET = 8'h35;
   localparam logic [7:0] PROTO_RESPONSE = 8'h03;
   // Return codes
   localparam logic [7:0] RC_OK = 8'h00;
   localparam logic [7:0] RC_NO_TASK = 8'h01;
   localparam logic [7:0] RC_OVERLAP = 8'h04;
   localparam logic [7:0] RC_NO_ACA = 8'h20;
   localparam logic [7:0] RC_INVALID = 8'hFF;
   // Request byte positions
   localparam logic [3:0] IDX_CODE = 4'h0;
   localparam logic [3:0] IDX_PROTO = 4'h1;
   localparam logic [3:0] IDX_TAG_HI = 4'h2;
   localparam logic [3:0] IDX_TAG_LO = 4'h3;
   localparam logic [3:0] IDX_PATH_LO = 4'h4;
   localparam logic [3:0] IDX_PATH_HI = 4'h7;
   localparam logic [3:0] IDX_LUN = 4'h8;
   // Index of the last response byte; response is five bytes
   localparam logic [2:0] RESP_LAST = 3'h4;
   // Queue-control encoding treated as untagged
   localparam logic [2:0] QTYPE_UNTAGGED = 3'h7;

   // True for a defined return code
   function automatic logic codeLegal(input logic [7:0] rc);
      return (rc == RC_OK) || (rc == RC_NO_TASK) || (rc == RC_OVERLAP) || (rc == RC_NO_ACA) || (rc == RC_INVALID);
   endfunction

   // Map reserved values onto invalid field
   function automatic logic [7:0] codeSafe(input logic [7:0] rc);
      return codeLegal(rc) ? rc : RC_INVALID;
   endfunction
endpackage

// *** design/lun_req_parser.sv ***
// Collects one LU reset request from the incoming message byte stream.
// Assumes bytes come from same-clock link logic; other messages pass unused.
`timescale 1ns/1ps
module lun_req_parser
   import lun_reset_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Byte stream in
   input wire logic rxValid,
   input wire logic [7:0] rxByte,
   input wire logic rxLast,
   output logic rxReady,
   // Decoded request
   output logic reqValid,
   output logic [15:0] reqTag,
   output logic [31:0] reqPath,
   output logic [7:0] reqLun,
   input wire logic reqTake
);
   typedef struct packed {
      logic [3:0] cnt;
      logic hdrOk;
      logic full;
      logic [15:0] tag;
      logic [31:0] path;
      logic [7:0] lun;
   } prs_t;
   prs_t r, next_r;

   // Byte capture and header check
   always_comb begin
      next_r = r;
      if (reqTake) begin
         next_r.full = 1'b0;
      end
      if (rxValid && rxReady) begin
         if (r.cnt == IDX_CODE) next_r.hdrOk = (rxByte == MSG_CODE); // [RULE12]
         if (r.cnt == IDX_PROTO) next_r.hdrOk = r.hdrOk && (rxByte == PROTO_LU_RESET); // [RULE12]
         if (r.cnt == IDX_TAG_HI) next_r.tag[15:8] = rxByte;
         if (r.cnt == IDX_TAG_LO) next_r.tag[7:0] = rxByte;
         if (r.cnt >= IDX_PATH_LO && r.cnt <= IDX_PATH_HI) next_r.path = {r.path[23:0], rxByte};
         if (r.cnt == IDX_LUN) next_r.lun = rxByte;
         if (r.cnt != 4'hF) next_r.cnt = r.cnt + 4'h1;
         if (rxLast) begin
            // Only a nine-byte message with both header codes counts
            next_r.full = r.hdrOk && (r.cnt == IDX_LUN); // [RULE12]
            next_r.cnt = IDX_CODE;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) r <= '0;
      else r <= next_r;
   end

   assign rxReady = !r.full;
   assign reqValid = r.full;
   assign reqTag = r.tag;
   assign reqPath = r.path;
   assign reqLun = r.lun;
endmodule

// *** design/lun_resp_tx.sv ***
// Sends one five-byte response message on a chosen logical path.
// Assumes the link side drains with txReady and may stall it.
`timescale 1ns/1ps
module lun_resp_tx
   import lun_reset_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Load from controller
   input wire logic load,
   input wire logic drop,
   input wire logic [15:0] tag,
   input wire logic [31:0] path,
   input wire logic [7:0] code,
   output logic busy,
   // Byte stream out
   output logic txValid,
   output logic [7:0] txByte,
   output logic txLast,
   output logic [31:0] txPath,
   input wire logic txReady
);
   typedef struct packed {
      logic busy;
      logic [2:0] idx;
      logic [39:0] sh;
      logic [31:0] path;
   } tx_t;
   tx_t r, next_r;

   // Load, then shift one byte per accepted beat
   always_comb begin
      next_r = r;
      if (drop) begin
         next_r.busy = 1'b0;
      end else if (load && !r.busy) begin
         next_r.busy = 1'b1;
         next_r.idx = 3'h0;
         next_r.sh = {MSG_CODE, PROTO_RESPONSE, tag, codeSafe(code)}; // [RULE17] [RULE18] [RULE23]
         next_r.path = path; // [RULE13]
      end else if (r.busy && txReady) begin
         next_r.sh = {r.sh[31:0], 8'h00};
         next_r.idx = r.idx + 3'h1;
         if (r.idx == RESP_LAST) next_r.busy = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) r <= '0;
      else r <= next_r;
   end

   assign busy = r.busy;
   assign txValid = r.busy;
   assign txByte = r.sh[39:32];
   assign txLast = r.busy && (r.idx == RESP_LAST);
   assign txPath = r.path;

   property p_hdr_first;
      @(posedge clk) disable iff (!rst_n) (txValid && r.idx == 3'h0) |-> txByte == MSG_CODE ##0 1;
   endproperty
   a_hdr_first: assert property (p_hdr_first) else $error("response header byte wrong"); // [RULE17]
   property p_code_byte;
      @(posedge clk) disable iff (!rst_n) txLast |-> codeLegal(txByte);
   endproperty
   a_code_byte: assert property (p_code_byte) else $error("reserved return code sent"); // [RULE23]
endmodule

// *** tb/initiator_model.sv ***
// Initiator model: sends message bytes, drains response bytes.
// Assumes the block's clock; drives 1 ns after rising edges.
`timescale 1ns/1ps
module initiator_model (
   // Clock and pacing
   input wire logic clk,
   input wire logic slow,
   // Message bytes out
   output logic rxValid,
   output logic [7:0] rxByte,
   output logic rxLast,
   input wire logic rxReady,
   // Response bytes in
   input wire logic txValid,
   input wire logic [7:0] txByte,
   input wire logic txLast,
   input wire logic [31:0] txPath,
   output logic txReady
);
   logic [7:0] respBytes[$]; // Captured bytes
   logic [31:0] respPath; // Path of last response
   int respCount; // Finished responses
   logic phase; // Stall toggle

   // Idle lines at time zero
   initial begin
      rxValid = 1'b0;
      rxByte = 8'h00;
      rxLast = 1'b0;
      txReady = 1'b1;
      phase = 1'b0;
      respCount = 0;
   end

   // Send n bytes first byte first, each held until taken
   task automatic send_msg(input logic [71:0] msg, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         #1;
         rxValid = 1'b1;
         rxByte = msg[71-8*i -: 8];
         rxLast = (i == n - 1);
         @(negedge clk);
         while (rxReady !== 1'b1) @(negedge clk);
      end
      @(posedge clk);
      #1;
      rxValid = 1'b0;
      rxByte = ~rxByte;
      rxLast = 1'b0;
   endtask

   // Take beats; stall every other cycle when slow
   always @(posedge clk) begin
      if (txValid && txReady) begin
         respBytes.push_back(txByte);
         if (txLast) begin
            respCount++;
            respPath = txPath;
         end
      end
      phase <= ~phase;
      txReady <= #1 (slow ? phase : 1'b1);
   end
endmodule

// *** tb/tb.sv ***
// Bench for the unit reset task-management block.
// Assumes initiator_model sends messages and drains responses.
`timescale 1ns/1ps
module tb;
   import lun_reset_pkg::*;
   localparam int NL = 8; // Units
   // Block inputs
   logic clk, rst_n, slow, dataReqPending, statusPending, hardResetEvt, linkResetEvt;
   logic [NL-1:0] lunAttached;
   logic extValid, cmdValid;
   logic [15:0] extTag, cmdTag;
   logic [31:0] extPath, cmdPath;
   logic [7:0] extCode;
   logic [2:0] cmdQueueType;
   // Block outputs and model links
   logic rxValid, rxLast, rxReady, flushReq, statusDrainReq, abortTasks, clearAca, releaseResv;
   logic reloadModes, unitAttnPowerOn, extReady, cmdReady, cmdReject, hardClear;
   logic txValid, txLast, txReady, busy;
   logic [7:0] rxByte, actLun, txByte, lastCode, seenLun;
   logic [31:0] txPath;
   int failures, numChecks, cycles, actCount, uaCount, rejCount, orderBad;

   lun_reset_task_mgmt #(.NUM_LUN(NL)) lun_reset_task_mgmt_inst (.clk(clk), .rst_n(rst_n),
      .rxValid(rxValid), .rxByte(rxByte), .rxLast(rxLast), .rxReady(rxReady), .lunAttached(lunAttached),
      .dataReqPending(dataReqPending), .flushReq(flushReq), .statusPending(statusPending),
      .statusDrainReq(statusDrainReq), .actLun(actLun), .abortTasks(abortTasks), .clearAca(clearAca),
      .releaseResv(releaseResv), .reloadModes(reloadModes), .unitAttnPowerOn(unitAttnPowerOn),
      .extValid(extValid), .extTag(extTag), .extPath(extPath), .extCode(extCode), .extReady(extReady),
      .cmdValid(cmdValid), .cmdQueueType(cmdQueueType), .cmdTag(cmdTag), .cmdPath(cmdPath),
      .cmdReady(cmdReady), .cmdReject(cmdReject), .hardResetEvt(hardResetEvt),
      .linkResetEvt(linkResetEvt), .hardClear(hardClear), .txValid(txValid), .txByte(txByte),
      .txLast(txLast), .txPath(txPath), .txReady(txReady), .busy(busy), .lastCode(lastCode));

   initiator_model initiator_model_inst (.clk(clk), .slow(slow), .rxValid(rxValid), .rxByte(rxByte),
      .rxLast(rxLast), .rxReady(rxReady), .txValid(txValid), .txByte(txByte), .txLast(txLast),
      .txPath(txPath), .txReady(txReady));

   // Clock, 5 ns period
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Count action, attention and reject pulses
   always @(posedge clk) begin
      cycles++;
      if (abortTasks && clearAca && releaseResv && reloadModes) begin
         actCount++;
         seenLun = actLun;
         if (dataReqPending || statusPending) orderBad++;
      end
      if (unitAttnPowerOn) uaCount++;
      if (unitAttnPowerOn && txValid) orderBad++;
      if (cmdReject) rejCount++;
      if (cycles == 20000) begin
         failures++;
         $display("timeout at %0t", $time);
         summarize();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Compare the five response bytes and the path
   task automatic check_resp(input logic [15:0] tg, input logic [7:0] rc, input logic [31:0] pth);
      logic [7:0] e [5] = '{MSG_CODE, PROTO_RESPONSE, tg[15:8], tg[7:0], rc};
      check(32'(initiator_model_inst.respBytes.size()), 32'h5);
      if (initiator_model_inst.respBytes.size() == 5) begin
         foreach (e[i]) check(32'(initiator_model_inst.respBytes[i]), 32'(e[i]));
      end
      check(initiator_model_inst.respPath, pth);
      initiator_model_inst.respBytes.delete();
   endtask

   task automatic wait_resp(input int n);
      int k = 0;
      while (initiator_model_inst.respCount < n && k < 300) begin
         @(posedge clk);
         k++;
      end
      #1;
      check(32'(initiator_model_inst.respCount), 32'(n));
   endtask

   // Hand one ext or cmd request over its handshake
   task automatic give(input logic isCmd);
      @(posedge clk);
      #1;
      cmdValid = isCmd;
      extValid = ~isCmd;
      @(negedge clk);
      while ((isCmd ? cmdReady : extReady) !== 1'b1) @(negedge clk);
      step(1);
      cmdValid = 1'b0;
      extValid = 1'b0;
   endtask

   task automatic t_ok;
      int a = actCount;
      int u = uaCount;
      int r = initiator_model_inst.respCount;
      dataReqPending = 1'b1;
      statusPending = 1'b1;
      initiator_model_inst.send_msg({MSG_CODE, PROTO_LU_RESET, 16'hA55A, 32'h1234_5678, 8'h03}, 9);
      step(4);
      check(32'(flushReq), 32'h1);
      check(32'(actCount - a), 32'h0);
      dataReqPending = 1'b0;
      step(3);
      check(32'(statusDrainReq), 32'h1);
      statusPending = 1'b0;
      wait_resp(r + 1);
      step(3);
      check(32'(actCount - a), 32'h1);
      check(32'(seenLun), 32'h3);
      check(32'(uaCount - u), 32'h1);
      check(32'(orderBad), 32'h0);
      check(32'(lastCode), 32'h0);
      check_resp(16'hA55A, 8'h00, 32'h1234_5678);
      $display("test unit reset done");
   endtask

   task automatic t_bad;
      logic [7:0] luns [2] = '{8'h04, 8'h09};
      int a = actCount;
      int u = uaCount;
      int r;
      slow = 1'b1;
      foreach (luns[i]) begin
         initiator_model_inst.send_msg({MSG_CODE, PROTO_LU_RESET, 8'hC3, luns[i], 24'hABCDEF, luns[i], luns[i]}, 9);
         wait_resp(initiator_model_inst.respCount + 1);
         check_resp({8'hC3, luns[i]}, 8'hFF, {24'hABCDEF, luns[i]});
      end
      // Wrong protocol code on an attached unit: no reset, no answer
      r = initiator_model_inst.respCount;
      initiator_model_inst.send_msg({MSG_CODE, 8'h32, 16'h0BAD, 32'h0000_0042, 8'h03}, 9);
      step(12);
      check(32'(initiator_model_inst.respCount - r), 32'h0);
      step(3);
      check(32'(actCount - a + uaCount - u), 32'h0);
      slow = 1'b0;
      $display("test bad unit done");
   endtask

   task automatic t_ext;
      logic [7:0] codes [7] = '{8'h00, 8'h01, 8'h04, 8'h20, 8'hFF, 8'h02, 8'h21};
      logic [7:0] want [7] = '{8'h00, 8'h01, 8'h04, 8'h20, 8'hFF, 8'hFF, 8'hFF};
      foreach (codes[i]) begin
         extTag = {8'h5E, codes[i]};
         extPath = 32'h0000_0100 + 32'(i);
         extCode = codes[i];
         give(1'b0);
         wait_resp(initiator_model_inst.respCount + 1);
         check_resp(extTag, want[i], extPath);
      end
      $display("test other codes done");
   endtask

   task automatic t_cmd;
      int n = rejCount;
      int r = initiator_model_inst.respCount;
      cmdTag = 16'h7777;
      cmdPath = 32'h0000_0777;
      cmdQueueType = QTYPE_UNTAGGED;
      give(1'b1);
      step(2);
      check(32'(rejCount - n), 32'h1);
      wait_resp(r + 1);
      check_resp(16'h7777, 8'hFF, 32'h0000_0777);
      cmdQueueType = 3'h0;
      give(1'b1);
      step(20);
      check(32'(rejCount - n), 32'h1);
      check(32'(initiator_model_inst.respCount - r), 32'h1);
      $display("test queue type done");
   endtask

   task automatic t_resets;
      int a = actCount;
      int r = initiator_model_inst.respCount;
      dataReqPending = 1'b1;
      initiator_model_inst.send_msg({MSG_CODE, PROTO_LU_RESET, 16'h1111, 32'h0000_0055, 8'h05}, 9);
      step(1);
      linkResetEvt = 1'b1;
      step(1);
      linkResetEvt = 1'b0;
      dataReqPending = 1'b0;
      wait_resp(r + 1);
      check_resp(16'h1111, 8'h00, 32'h0000_0055);
      step(3);
      check(32'(actCount - a), 32'h1);
      a = actCount;
      dataReqPending = 1'b1;
      initiator_model_inst.send_msg({MSG_CODE, PROTO_LU_RESET, 16'h2222, 32'h0000_0066, 8'h03}, 9);
      step(2);
      hardResetEvt = 1'b1;
      step(1);
      hardResetEvt = 1'b0;
      check(32'(hardClear), 32'h1);
      step(1);
      check(32'(busy), 32'h0);
      dataReqPending = 1'b0;
      step(30);
      check(32'(initiator_model_inst.respCount - r + actCount - a), 32'h1);
      $display("test node resets done");
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      {failures, numChecks, cycles, actCount, uaCount, rejCount, orderBad} = '0;
      {rst_n, slow, dataReqPending, statusPending, hardResetEvt, linkResetEvt, extValid, cmdValid} = '0;
      lunAttached = 8'h28;
      {extTag, cmdTag, extPath, cmdPath, extCode, cmdQueueType} = '0;
      step(20);
      rst_n = 1'b1;
      step(3);
      t_ok();
      t_bad();
      t_ext();
      t_cmd();
      t_resets();
      summarize();
   end
endmodule
